/* core/sadcs_map.vh */
// Register indices, field positions, reset values and counts of the converter sequencer.
`ifndef SADCS_MAP_VH
`define SADCS_MAP_VH
// Word indices; the byte address is four times the index.
`define SADCS_IDX_RES_LAST 4'h7
`define SADCS_IDX_CTRL 4'h8
`define SADCS_IDX_CHEN 4'h9
`define SADCS_IDX_CMP 4'hA
`define SADCS_IDX_STAT 4'hB
`define SADCS_IDX_CAL 4'hC
`define SADCS_IDX_CSEL 4'hD
`define SADCS_IDX_CDIV 4'hE
// Result word fields.
`define SADCS_RES_VALID 16
`define SADCS_RES_OVR 17
// Control word fields.
`define SADCS_CTRL_IE 0
`define SADCS_CTRL_MODE_LO 1
`define SADCS_CTRL_MODE_HI 2
`define SADCS_CTRL_DIFF 3
`define SADCS_CTRL_TRGEN 4
`define SADCS_CTRL_START 5
// Operating modes.
`define SADCS_MODE_SINGLE 2'h0
`define SADCS_MODE_SCAN 2'h2
`define SADCS_MODE_CONT 2'h3
// Channel enable word fields.
`define SADCS_CHEN_SRC_LO 8
`define SADCS_CHEN_SRC_HI 9
// Compare word fields.
`define SADCS_CMP_VAL_HI 11
`define SADCS_CMP_CH_LO 12
`define SADCS_CMP_CH_HI 14
`define SADCS_CMP_GE 15
`define SADCS_CMP_EN 16
`define SADCS_CMP_IE 17
// Status word fields.
`define SADCS_STAT_END 0
`define SADCS_STAT_CMPF 1
`define SADCS_STAT_BUSY 2
`define SADCS_STAT_CH_LO 3
`define SADCS_STAT_CH_HI 5
// Calibration word fields.
`define SADCS_CAL_EN 0
`define SADCS_CAL_DONE 1
// Clock select and divider fields.
`define SADCS_CSEL_LO 2
`define SADCS_CSEL_HI 3
`define SADCS_CDIV_LO 16
`define SADCS_CDIV_HI 23
// Calibration length in converter clocks, and last count value.
`define SADCS_CAL_CLOCKS 7'h7F
`define SADCS_CAL_LAST 7'h7E
// Bus answers and reset values.
`define SADCS_RESP_OKAY 2'h0
`define SADCS_RESP_SLVERR 2'h2
`define SADCS_ZERO32 32'h00000000
`endif

/* core/sadcs_clkgen.v */
// Converter clock generator: source select and divide-by-(N+1) prescaler.
`timescale 1ns/1ns
module sadcs_clkgen (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_clk_en,
  input wire [3:0] i_src_tick,
  input wire [1:0] i_src_sel,
  input wire [7:0] i_divider,
  output reg o_tick
);

  reg [7:0] count_reg;
  wire src_tick = i_src_tick[i_src_sel];

  ////////////////////////////////////////////////////////////////////////////
  // One converter clock per divider+1 ticks of the chosen source.
  // A divider of zero passes every source tick; a source running at the
  // bus rate then gives a converter clock as fast as the bus itself.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      count_reg <= 8'h00;
      o_tick <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_tick <= 1'b0;
      if (src_tick)
      begin
        if (count_reg >= i_divider)
        begin
          count_reg <= 8'h00;
          o_tick <= 1'b1;
        end
        else
          count_reg <= count_reg + 8'h01;
      end
    end
  end

endmodule

/* core/sadcs_top.v */
// Sequencer and register file for an eight-channel 12-bit SAR converter.
// Contract
// - One 12-bit converter, eight input channels.
// - Three modes: single, scan, continuous scan.
// - Start by software bit or trigger pin.
// - Single mode converts one channel, then stops.
// - Scan converts enabled channels ascending once.
// - Continuous scan repeats until software halts.
// - Per-channel result with valid and overrun.
// - Compare results; optional compare interrupt.
// - Channel 7 source: pin, bandgap, sensor.
// - Eight single-ended or four differential inputs.
// - Calibration lasts 127 converter clocks, sets done.
// - Two-bit field selects one of four sources.
// - Converter clock is source over divider+1.
// - Hardware clears start bit at sequence end.
// - End flag set; interrupt when enabled.
// - Single mode uses lowest enabled channel only.
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "sadcs_map.vh"
module sadcs_top (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_clk_en,
  input wire [7:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [7:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  input wire [3:0] i_src_tick,
  input wire i_ext_trigger_pin,
  input wire i_adc_done,
  input wire [11:0] i_adc_data,
  output reg o_adc_tick,
  output reg o_adc_start,
  output reg [2:0] o_adc_chsel,
  output reg [1:0] o_adc_ch7_src,
  output reg o_adc_diff,
  output reg o_adc_calib,
  output reg o_conv_irq
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ARM = 4'h2;
  localparam [3:0] ST_CONV = 4'h4;
  localparam [3:0] ST_CAL = 4'h8;

  reg [3:0] state_reg;
  reg [5:0] ctrl_reg;
  reg [9:0] chen_reg;
  reg [17:0] cmp_reg;
  reg end_flag_reg;
  reg cmp_flag_reg;
  reg calib_enable_reg;
  reg cal_done_reg;
  reg [6:0] cal_cnt_reg;
  reg [1:0] csel_reg;
  reg [7:0] cdiv_reg;
  reg [2:0] chan_reg;
  reg trig_last_reg;
  reg [11:0] res_data_reg [0:7];
  reg [7:0] res_valid_reg;
  reg [7:0] res_ovr_reg;
  reg [31:0] wr_word;
  reg [31:0] wr_mask;
  reg low_found;
  reg [2:0] low_ch;
  reg nxt_found;
  reg [2:0] nxt_ch;
  integer k;

  wire conv_tick;
  wire [3:0] aw_idx = i_s_axi_awaddr[5:2];
  wire [3:0] ar_idx = i_s_axi_araddr[5:2];
  wire wr_fire = i_clk_en & o_s_axi_awready & i_s_axi_awvalid & i_s_axi_wvalid;
  wire rd_fire = i_clk_en & o_s_axi_arready & i_s_axi_arvalid;
  wire wr_hit = ~i_s_axi_awaddr[7] & ~i_s_axi_awaddr[6] & (aw_idx != 4'hF);
  wire rd_hit = ~i_s_axi_araddr[7] & ~i_s_axi_araddr[6] & (ar_idx != 4'hF);
  wire [1:0] mode = ctrl_reg[`SADCS_CTRL_MODE_HI:`SADCS_CTRL_MODE_LO];
  wire start_bit = ctrl_reg[`SADCS_CTRL_START];
  wire store_now = i_clk_en & state_reg[2] & i_adc_done;
  wire rd_res_clr = rd_fire & rd_hit & (ar_idx <= `SADCS_IDX_RES_LAST);
  wire [11:0] cmp_val = cmp_reg[`SADCS_CMP_VAL_HI:0];
  wire cmp_ge = i_adc_data >= cmp_val;
  // Compare against the channel just converted, in the chosen direction.
  // compare on store
  wire cmp_hit = store_now & cmp_reg[`SADCS_CMP_EN]
    & (chan_reg == cmp_reg[`SADCS_CMP_CH_HI:`SADCS_CMP_CH_LO])
    & (cmp_ge == cmp_reg[`SADCS_CMP_GE]);
  wire trig_rise = ctrl_reg[`SADCS_CTRL_TRGEN] & i_ext_trigger_pin & ~trig_last_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Converter clock generator.
  // divided converter clock
  sadcs_clkgen u_clkgen (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_src_tick(i_src_tick),
    .i_src_sel(csel_reg),
    .i_divider(cdiv_reg),
    .o_tick(conv_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register read view; also the old value for byte-lane merges on write.
  function [31:0] reg_view;
    input [3:0] idx;
    begin
      reg_view = `SADCS_ZERO32;
      case (idx)
        `SADCS_IDX_CTRL: reg_view[5:0] = ctrl_reg;
        `SADCS_IDX_CHEN: reg_view[9:0] = chen_reg;
        `SADCS_IDX_CMP: reg_view[17:0] = cmp_reg;
        `SADCS_IDX_STAT:
        begin
          reg_view[`SADCS_STAT_END] = end_flag_reg;
          reg_view[`SADCS_STAT_CMPF] = cmp_flag_reg;
          reg_view[`SADCS_STAT_BUSY] = ~state_reg[0];
          reg_view[`SADCS_STAT_CH_HI:`SADCS_STAT_CH_LO] = chan_reg;
        end
        `SADCS_IDX_CAL:
        begin
          reg_view[`SADCS_CAL_EN] = calib_enable_reg;
          reg_view[`SADCS_CAL_DONE] = cal_done_reg;
        end
        `SADCS_IDX_CSEL: reg_view[`SADCS_CSEL_HI:`SADCS_CSEL_LO] = csel_reg;
        `SADCS_IDX_CDIV: reg_view[`SADCS_CDIV_HI:`SADCS_CDIV_LO] = cdiv_reg;
        default:
        begin
          if (idx <= `SADCS_IDX_RES_LAST)
          begin
            reg_view[11:0] = res_data_reg[idx[2:0]];
            reg_view[`SADCS_RES_VALID] = res_valid_reg[idx[2:0]];
            reg_view[`SADCS_RES_OVR] = res_ovr_reg[idx[2:0]];
          end
        end
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Merge write data into the old value under the byte strobes.
  always @*
  begin
    wr_mask = {{8{i_s_axi_wstrb[3]}}, {8{i_s_axi_wstrb[2]}},
               {8{i_s_axi_wstrb[1]}}, {8{i_s_axi_wstrb[0]}}};
    wr_word = (reg_view(aw_idx) & ~wr_mask) | (i_s_axi_wdata & wr_mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lowest enabled channel, and the next enabled one above the current.
  // ascending channel search
  always @*
  begin
    low_found = 1'b0;
    low_ch = 3'h0;
    nxt_found = 1'b0;
    nxt_ch = 3'h0;
    for (k = 7; k >= 0; k = k - 1)
    begin
      if (chen_reg[k])
      begin
        low_found = 1'b1;
        low_ch = k[2:0];
        if (k[2:0] > chan_reg)
        begin
          nxt_found = 1'b1;
          nxt_ch = k[2:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result storage: one word per channel. A new result over one still
  // unread marks overrun; reading the word clears both indicators, but a
  // result landing in the same cycle wins over the read.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_res
      wire hit_store = store_now & (chan_reg == g);
      wire hit_read = rd_res_clr & (ar_idx[2:0] == g);
      always @(posedge i_clock)
      begin
        if (i_sys_rst)
        begin
          res_data_reg[g] <= 12'h000;
          res_valid_reg[g] <= 1'b0;
          res_ovr_reg[g] <= 1'b0;
        end
        else if (hit_store)
        begin
          res_data_reg[g] <= i_adc_data;
          res_valid_reg[g] <= 1'b1;
          res_ovr_reg[g] <= res_valid_reg[g];
        end
        else if (hit_read)
        begin
          res_valid_reg[g] <= 1'b0;
          res_ovr_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one write and one read at a time; unmapped gets SLVERR.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `SADCS_RESP_OKAY;
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rresp <= `SADCS_RESP_OKAY;
      o_s_axi_rdata <= `SADCS_ZERO32;
    end
    else if (i_clk_en)
    begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_arready <= 1'b0;
      if (wr_fire)
      begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_hit ? `SADCS_RESP_OKAY : `SADCS_RESP_SLVERR;
      end
      else if (o_s_axi_bvalid)
      begin
        if (i_s_axi_bready)
          o_s_axi_bvalid <= 1'b0;
      end
      else if (i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_awready)
      begin
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
      if (rd_fire)
      begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= reg_view(ar_idx);
        o_s_axi_rresp <= rd_hit ? `SADCS_RESP_OKAY : `SADCS_RESP_SLVERR;
      end
      else if (o_s_axi_rvalid)
      begin
        if (i_s_axi_rready)
          o_s_axi_rvalid <= 1'b0;
      end
      else if (i_s_axi_arvalid & ~o_s_axi_arready)
        o_s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control registers and the conversion sequencer. Flags that hardware
  // sets are cleared by writing one; a set in the same cycle wins.
  // reset to idle
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      state_reg <= ST_IDLE;
      ctrl_reg <= 6'h00;
      chen_reg <= 10'h000;
      cmp_reg <= 18'h00000;
      end_flag_reg <= 1'b0;
      cmp_flag_reg <= 1'b0;
      calib_enable_reg <= 1'b0;
      cal_done_reg <= 1'b0;
      cal_cnt_reg <= 7'h00;
      csel_reg <= 2'h0;
      cdiv_reg <= 8'h00;
      chan_reg <= 3'h0;
      trig_last_reg <= 1'b0;
      o_adc_tick <= 1'b0;
      o_adc_start <= 1'b0;
      o_adc_chsel <= 3'h0;
      o_adc_ch7_src <= 2'h0;
      o_adc_diff <= 1'b0;
      o_adc_calib <= 1'b0;
      o_conv_irq <= 1'b0;
    end
    else if (i_clk_en)
    begin
      trig_last_reg <= i_ext_trigger_pin;
      o_adc_tick <= conv_tick;
      o_adc_start <= 1'b0;
      // Software writes; flag clears come first so hardware sets override.
      if (wr_fire)
      begin
        case (aw_idx)
          `SADCS_IDX_CTRL: ctrl_reg <= wr_word[5:0];
          `SADCS_IDX_CHEN: chen_reg <= wr_word[9:0];
          `SADCS_IDX_CMP: cmp_reg <= wr_word[17:0];
          `SADCS_IDX_STAT:
          begin
            if (wr_word[`SADCS_STAT_END])
              end_flag_reg <= 1'b0;
            if (wr_word[`SADCS_STAT_CMPF])
              cmp_flag_reg <= 1'b0;
          end
          `SADCS_IDX_CAL:
          begin
            if (wr_word[`SADCS_CAL_EN])
            begin
              calib_enable_reg <= 1'b1;
              cal_done_reg <= 1'b0;
            end
          end
          `SADCS_IDX_CSEL: csel_reg <= wr_word[`SADCS_CSEL_HI:`SADCS_CSEL_LO];
          `SADCS_IDX_CDIV: cdiv_reg <= wr_word[`SADCS_CDIV_HI:`SADCS_CDIV_LO];
          default:
          begin
          end
        endcase
      end
      if (trig_rise)
        ctrl_reg[`SADCS_CTRL_START] <= 1'b1;
      if (cmp_hit)
        cmp_flag_reg <= 1'b1;
      case (state_reg)
        ST_IDLE:
        begin
          if (calib_enable_reg)
          begin
            cal_cnt_reg <= 7'h00;
            state_reg <= ST_CAL;
          end
          else if (start_bit)
          begin
            if (low_found)
            begin
              chan_reg <= low_ch;
              state_reg <= ST_ARM;
            end
            else
              ctrl_reg[`SADCS_CTRL_START] <= 1'b0;
          end
        end
        ST_ARM:
        begin
          // Launch on a converter clock so the core sees whole periods.
          if (~start_bit)
            state_reg <= ST_IDLE;
          else if (conv_tick)
          begin
            o_adc_start <= 1'b1;
            state_reg <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (i_adc_done)
          begin
            if (mode == `SADCS_MODE_SINGLE)
            begin
              end_flag_reg <= 1'b1;
              ctrl_reg[`SADCS_CTRL_START] <= 1'b0;
              state_reg <= ST_IDLE;
            end
            else if (~start_bit)
              state_reg <= ST_IDLE;
            else if (nxt_found)
            begin
              chan_reg <= nxt_ch;
              state_reg <= ST_ARM;
            end
            else if (mode == `SADCS_MODE_CONT)
            begin
              end_flag_reg <= 1'b1;
              chan_reg <= low_ch;
              state_reg <= ST_ARM;
            end
            else
            begin
              end_flag_reg <= 1'b1;
              ctrl_reg[`SADCS_CTRL_START] <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_CAL:
        begin
          if (conv_tick)
          begin
            cal_cnt_reg <= cal_cnt_reg + 7'h01;
            if (cal_cnt_reg == `SADCS_CAL_LAST)
            begin
              cal_done_reg <= 1'b1;
              calib_enable_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // Converter-facing levels, registered so the core sees clean pins.
      // channel select out
      o_adc_chsel <= chan_reg;
      o_adc_ch7_src <= chen_reg[`SADCS_CHEN_SRC_HI:`SADCS_CHEN_SRC_LO];
      o_adc_diff <= ctrl_reg[`SADCS_CTRL_DIFF];
      o_adc_calib <= state_reg[3];
      o_conv_irq <= (end_flag_reg & ctrl_reg[`SADCS_CTRL_IE])
        | (cmp_flag_reg & cmp_reg[`SADCS_CMP_IE]);
    end
  end

endmodule

/* tb/sadcs_top_asserts.sv */
// Port-level checks of the converter sequencer.
`timescale 1ns/1ns
module sadcs_top_asserts (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_s_axi_bready,
  input wire i_s_axi_rready,
  input wire o_s_axi_awready,
  input wire o_s_axi_wready,
  input wire o_s_axi_bvalid,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid,
  input wire [31:0] o_s_axi_rdata,
  input wire o_adc_tick,
  input wire o_adc_start,
  input wire [2:0] o_adc_chsel,
  input wire o_adc_calib,
  input wire o_conv_irq
);
  int cal_cnt;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Counts converter clocks while calibrating; the window allows one clock of pipeline skew.
  always @(posedge i_clock)
  begin
    if (i_sys_rst || !o_adc_calib)
      cal_cnt <= 0;
    else if (o_adc_tick)
      cal_cnt <= cal_cnt + 1;
  end
  ////////////////////////////////////////////////////////////
  property p_rst_idle;
    $fell(i_sys_rst) |-> !o_adc_start && !o_adc_calib && !o_conv_irq && !o_s_axi_bvalid;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("output active right after reset");
  property p_start_pulse;
    o_adc_start |=> !o_adc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse longer than one cycle");
  property p_chsel_hold;
    o_adc_start |=> $stable(o_adc_chsel);
  endproperty
  a_chsel_hold: assert property (p_chsel_hold)
    else $error("channel changed during conversion");
  property p_calib_len;
    $fell(o_adc_calib) |-> cal_cnt >= 126 && cal_cnt <= 128;
  endproperty
  a_calib_len: assert property (p_calib_len)
    else $error("calibration length wrong");
  property p_aw_w;
    o_s_axi_awready == o_s_axi_wready;
  endproperty
  a_aw_w: assert property (p_aw_w)
    else $error("address and data ready differ");
  property p_aw_gap;
    o_s_axi_awready |=> !o_s_axi_awready [*2];
  endproperty
  a_aw_gap: assert property (p_aw_gap)
    else $error("write accepted too soon");
  property p_wr_resp;
    o_s_axi_awready |=> o_s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
  property p_rd_resp;
    o_s_axi_arready |=> o_s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read data late");
  property p_b_hold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped or changed");
  c_start: cover property (o_adc_start);
  c_calib: cover property ($fell(o_adc_calib));
  c_irq: cover property ($rose(o_conv_irq));
endmodule
bind sadcs_top sadcs_top_asserts u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_s_axi_bready(i_s_axi_bready), .i_s_axi_rready(i_s_axi_rready),
  .o_s_axi_awready(o_s_axi_awready), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid), .o_s_axi_rdata(o_s_axi_rdata), .o_adc_tick(o_adc_tick),
  .o_adc_start(o_adc_start), .o_adc_chsel(o_adc_chsel), .o_adc_calib(o_adc_calib),
  .o_conv_irq(o_conv_irq));

/* tb/sadcs_core_model.sv */
// Behavioural model of the analog converter core.
`timescale 1ns/1ns
module sadcs_core_model (
  input wire i_clock,
  input wire i_start,
  input wire [2:0] i_chsel,
  input wire i_slow,
  output reg o_done,
  output reg [11:0] o_data
);
  int wait_cnt = -1;
  logic [8:0] seq = 9'h0;
  initial o_done = 1'b0;
  initial o_data = 12'hA5A;
  // Answers each start promptly or slowly; data toggles outside the done cycle.
  always @(posedge i_clock)
  begin
    o_done <= 1'b0;
    o_data <= ~o_data;
    if (i_start)
      wait_cnt <= i_slow ? 6 : 0;
    else if (wait_cnt > 0)
      wait_cnt <= wait_cnt - 1;
    else if (wait_cnt == 0)
    begin
      o_done <= 1'b1;
      o_data <= {i_chsel, seq};
      seq <= seq + 9'h35;
      wait_cnt <= -1;
    end
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ns
module testbench;
  logic clk, rst, cen, awv, wv, bre, arv, rre, trig, slow, done;
  logic awr, wrdy, bv, arr, rv, atick, ast, dif, cal, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] tick;
  logic [1:0] br, rr, c7;
  logic [2:0] ach;
  logic [11:0] dat;
  logic [11:0] val[8] = '{default: 12'h0};
  logic vld[8] = '{default: 1'b0};
  logic ovr[8] = '{default: 1'b0};
  int err_count, tests_run, seed, pat[$], cq[$];
  sadcs_top dut (.i_clock(clk), .i_sys_rst(rst), .i_clk_en(cen), .i_s_axi_awaddr(awa),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bre), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre),
    .i_src_tick(tick), .i_ext_trigger_pin(trig), .i_adc_done(done), .i_adc_data(dat),
    .o_adc_tick(atick), .o_adc_start(ast), .o_adc_chsel(ach), .o_adc_ch7_src(c7),
    .o_adc_diff(dif), .o_adc_calib(cal), .o_conv_irq(irq));
  sadcs_core_model core (.i_clock(clk), .i_start(ast), .i_chsel(ach), .i_slow(slow),
    .o_done(done), .o_data(dat));
  // Free-running 250 MHz clock.
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // Random ticks on the three non-bus sources; the bus-clock source stays high.
  always @(posedge clk) tick[3:1] <= 3'($random(seed));
  // Reference store of what every result word must hold; a second store sets overrun.
  always @(posedge clk)
  begin
    if (done)
    begin
      cq.push_back(ach);
      ovr[ach] = ovr[ach] | vld[ach];
      vld[ach] = 1;
      val[ach] = dat;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic final_report;
  begin
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task automatic tmo;
  begin
    err_count++;
    final_report();
  end
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
  begin
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  end
  endtask
  // Bus write; index 15 is unmapped and must be refused.
  task automatic wr(input [3:0] ix, input [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge clk);
    awa <= {2'h0, ix, 2'h0};
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do @(posedge clk); while (!awr && ++n < 99);
    awv <= 0;
    wv <= 0;
    while (!bv && ++n < 99) @(posedge clk);
    if (n >= 99) tmo();
    chk("bresp", br, (ix == 15) ? 2 : 0);
    bre <= 0;
  end
  endtask
  task automatic rd(input [3:0] ix, output logic [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge clk);
    ara <= {2'h0, ix, 2'h0};
    arv <= 1;
    rre <= 1;
    do @(posedge clk); while (!arr && ++n < 99);
    arv <= 0;
    while (!rv && ++n < 99) @(posedge clk);
    if (n >= 99) tmo();
    d = rdat;
    chk("rresp", rr, (ix == 15) ? 2 : 0);
    rre <= 0;
  end
  endtask
  // One conversion run in mode m over channel set en, started by bit or by pin.
  task automatic run(input [1:0] m, input [7:0] en, input trg);
    int k, n;
    logic [31:0] d;
  begin
    pat.delete();
    for (k = 0; k < 8; k++)
      if (en[k] && (m != 0 || pat.size() == 0))
        pat.push_back(k);
    // start cleared before the mode changes
    wr(8, 0);
    // start held low over a whole converter clock
    for (k = 0, n = 0; n < 2 && k < 999; k++)
      @(posedge clk) n += atick;
    if (k >= 999) tmo();
    wr(9, {24'h0, en});
    cq.delete();
    wr(8, {26'h0, !trg, trg, 1'b0, m, 1'b1});
    if (trg)
    begin
      repeat (4) @(posedge clk);
      trig <= 1;
      repeat (6) @(posedge clk);
      trig <= 0;
    end
    for (k = 0, n = 0; k < (m == 3 ? 2 : 1); n++)
    begin
      if (n > 300) tmo();
      rd(11, d);
      if (d[0])
      begin
        k++;
        if (m != 3)
          chk("irq", irq, 1);
        wr(11, 1);
      end
    end
    if (m == 3)
      wr(8, 7);
    d = 4;
    for (n = 0; d[2]; n++)
    begin
      if (n > 300) tmo();
      rd(11, d);
    end
    rd(8, d);
    chk("start", d[5], 0);
    for (k = 0; k < cq.size(); k++)
      chk("chan", cq[k], pat[k % pat.size()]);
    n = (m == 3) ? cq.size() >= 2 * pat.size() : cq.size() == pat.size();
    chk("count", n, 1);
    for (k = 0; k < 8; k++)
    begin
      rd(k, d);
      chk("result", d, {14'h0, ovr[k], vld[k], 4'h0, val[k]});
      vld[k] = 0;
      ovr[k] = 0;
    end
    wr(11, 1);
  end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    int k, n;
    logic [31:0] d;
    {rst, awv, wv, bre, arv, rre, trig, slow} = 8'h80;
    cen = 1;
    {awa, ara, wd} = 48'h0;
    tick = 4'h1;
    seed = 32'h8f6098c7;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rst <= 0;
    for (k = 0; k < 16; k++)
    begin
      rd(k, d);
      chk("reset", d, 0);
    end
    wr(15, 1);
    // dividers keep the converter clock at or below 16 MHz
    for (k = 1; k < 4; k++)
    begin
      wr(14, (16 * k - 1) << 16);
      repeat (8) @(posedge clk);
      n = 0;
      repeat (96) @(posedge clk) n += atick;
      chk("ticks", n, 96 / (16 * k));
    end
    // Clock enable low: the converter tick output must stand still past a converter period.
    cen <= 0;
    repeat (2) @(posedge clk);
    d[0] = atick;
    n = 0;
    repeat (60) @(posedge clk) n += (atick != d[0]);
    chk("freeze", n, 0);
    cen <= 1;
    wr(12, 1);
    d = 0;
    for (n = 0; !d[1]; n++)
    begin
      if (n > 3000) tmo();
      rd(12, d);
    end
    chk("calib", d[1:0], 2);
    for (k = 0; k < 4; k++)
    begin
      wr(13, k << 2);
      wr(14, (k == 0) ? 32'hF0000 : 32'h70000);
      run(0, 8'($random(seed)) | 8'h80, 0);
    end
    run(2, 8'($random(seed)) | 8'h01, 0);
    run(2, 8'($random(seed)) | 8'h08, 1);
    slow = 1;
    run(3, 8'($random(seed)) | 8'h40, 0);
    slow = 0;
    for (k = 0; k < 2; k++)
    begin
      wr(10, {14'h0, 1'b1, 1'b1, k[0], 3'h5, 12'h0});
      run(0, 8'h20, 0);
      rd(11, d);
      chk("cmpflag", d[1], k);
      chk("cmpirq", irq, k);
      wr(11, 2);
      repeat (2) @(posedge clk);
      chk("irqclr", irq, 0);
    end
    for (k = 0; k < 3; k++)
    begin
      wr(9, k << 8);
      repeat (2) @(posedge clk);
      chk("ch7src", c7, k);
    end
    wr(8, 8);
    repeat (2) @(posedge clk);
    chk("diff", dif, 1);
    // recalibrate after switching the input type
    wr(12, 1);
    rd(12, d);
    chk("recal", d[1:0], 1);
    final_report();
  end
endmodule
